// ==== src/pic_pkg.sv ====
// Purpose: Constants shared by the prioritized interrupt controller.
// Assumes: 100 MHz system clock, 20-bit vector addresses.
// Notes: Priority index equals latch and enable index for sources 2..39.
package pic_pkg;
  localparam int PIC_NUM_PRIO = 40;
  localparam int PIC_VEC_W = 20;
  localparam int PIC_IDX_W = 6;
  localparam logic [5:0] PIC_PRIO_SWI = 6'h01;
  localparam logic [5:0] PIC_PRIO_WDT = 6'h02;
  localparam logic [5:0] PIC_PRIO_EXT0 = 6'h03;
  localparam logic [5:0] PIC_PRIO_FIRST_HI = 6'h20;
  localparam logic [19:0] PIC_VEC_RESET = 20'hffffc;
  localparam logic [19:0] PIC_VEC_SWI = 20'hffff8;
  localparam logic [19:0] PIC_VEC_WDT = 20'hffff4;
  localparam logic [19:0] PIC_VEC_LO_BASE = 20'hffffc;
  localparam logic [19:0] PIC_VEC_HI_BASE = 20'hfff3c;
  localparam logic [39:0] PIC_LATCH_RST = 40'h00_0000_0000;
  localparam logic [39:0] PIC_ENABLE_RST = 40'h00_0000_0000;
  // Slots 4,7,9,11,13,14,17,19,21,23,25,28,37 have no hardware source
  localparam logic [39:0] PIC_RESERVED_MAP = 40'h20_12aa_6a90;
  localparam logic [39:0] PIC_PNMI_MAP = 40'h00_0000_0006;
endpackage

// ==== src/pic_prio_enc.sv ====
// Purpose: Fixed-priority encoder, lowest index wins.
// Assumes: Request vector is already gated by enables.
// Notes: Purely combinational.
`timescale 1ns/10ps
module pic_prio_enc import pic_pkg::*; #(
  parameter int N = 40
) (
  input wire logic [N-1:0] req_i, // Gated requests
  output logic found_o, // Any request present
  output logic [5:0] idx_o // Winning index
);
  // Scan from the lowest priority upward so the highest overwrites last
  always_comb begin
    found_o = 1'b0;
    idx_o = 6'h00;
    for (int k = N - 1; k >= 0; k--) begin
      if (req_i[k]) begin
        found_o = 1'b1;
        idx_o = 6'(k);
      end
    end
  end
endmodule

// ==== src/pic_ctrl.sv ====
// Purpose: Prioritized interrupt controller handing vectors to the CPU core.
// Assumes: All inputs synchronous to clk_i; CPU acknowledges with accept_ack_i.
// Notes: Software and watchdog sources bypass all enables.
`timescale 1ns/10ps

module pic_ctrl import pic_pkg::*; #(
  parameter int NPRIO = PIC_NUM_PRIO
) (
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Asynchronous reset, active low
  input wire logic [39:0] irq_src_i, // Source request pulses by priority index
  input wire logic software_irq_i, // Software interrupt instruction
  input wire logic [39:0] source_enable_flag_i, // Individual enables by index
  input wire logic master_set_i, // Enable-all instruction
  input wire logic master_clr_i, // Disable-all instruction
  input wire logic ret_mask_i, // Maskable return: master enable to one
  input wire logic ret_nmi_i, // Non-maskable return: restore stacked value
  input wire logic ret_stacked_i, // Stacked master enable restored by CPU
  input wire logic [39:0] latch_clr_i, // Software latch clear, one bit each
  input wire logic ext0_pin_function_enable_i, // Pin function enable for ext 0
  input wire logic accept_ack_i, // CPU takes the offered interrupt
  output logic accept_req_o, // Interrupt offered to the CPU
  output logic [19:0] vector_o, // Vector of offered source
  output logic [5:0] prio_o, // Priority index of offered source
  output logic stacked_imf_o, // Master enable value to stack
  output logic master_irq_enable_o, // Current master enable
  output logic [39:0] request_latch_o // Latch contents, readable
);
  typedef struct packed {
    logic [39:0] latch;
    logic master_irq_enable;
    logic swi_pend;
    logic req;
    logic [19:0] vec;
    logic [5:0] prio;
    logic stk;
  } pic_state_s;

  pic_state_s st;
  pic_state_s next_st;
  logic rst_s1;
  logic rst_n;
  logic [39:0] gated;
  logic found;
  logic [5:0] win;

  // Vector for a priority index, shared by offer logic and checks
  function automatic logic [19:0] pic_vec_of(input logic [5:0] p);
    logic [19:0] v;
    v = PIC_VEC_RESET;
    if (p == PIC_PRIO_SWI) begin
      v = PIC_VEC_SWI;
    end else if (p == PIC_PRIO_WDT) begin
      v = PIC_VEC_WDT;
    end else if (p < PIC_PRIO_FIRST_HI) begin
      v = PIC_VEC_LO_BASE - {12'h000, p, 2'b00};
    end else begin
      v = PIC_VEC_HI_BASE - {12'h000, p - PIC_PRIO_FIRST_HI, 2'b00};
    end
    return v;
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Enable gating per source
  always_comb begin
    gated = '0;
    for (int k = 2; k < NPRIO; k++) begin
      if (PIC_PNMI_MAP[k]) begin
        gated[k] = st.latch[k];
      end else if (k == int'(PIC_PRIO_EXT0)) begin
        gated[k] = st.latch[k] & st.master_irq_enable & source_enable_flag_i[k] & ext0_pin_function_enable_i;
      end else begin
        gated[k] = st.latch[k] & st.master_irq_enable & source_enable_flag_i[k];
      end
    end
    // software interrupt has no latch but a pending flag
    gated[PIC_PRIO_SWI] = st.swi_pend;
  end

  pic_prio_enc #(.N(NPRIO)) u_enc (
    .req_i(gated),
    .found_o(found),
    .idx_o(win)
  );

  // Next state: latch, master enable, offer
  always_comb begin
    next_st = st;
    next_st.latch = st.latch & ~latch_clr_i;
    if (accept_ack_i && st.req) begin
      next_st.latch[st.prio] = 1'b0;
      if (st.prio == PIC_PRIO_SWI) begin
        next_st.swi_pend = 1'b0;
      end
      next_st.stk = st.master_irq_enable;
      next_st.master_irq_enable = 1'b0;
      next_st.req = 1'b0;
    end else begin
      if (master_set_i || ret_mask_i) begin
        next_st.master_irq_enable = 1'b1;
      end else if (ret_nmi_i) begin
        next_st.master_irq_enable = ret_stacked_i;
      end else if (master_clr_i) begin
        next_st.master_irq_enable = 1'b0;
      end
      // re-evaluate the offer each cycle, allowing nesting
      next_st.req = found;
      next_st.prio = win;
      next_st.vec = pic_vec_of(win);
    end
    // set wins over clear; reserved slots never set
    next_st.latch = next_st.latch | (irq_src_i & ~PIC_RESERVED_MAP & ~PIC_PNMI_MAP)
      | (irq_src_i & PIC_PNMI_MAP & 40'h00_0000_0004);
    next_st.latch[1:0] = 2'b00;
    if (software_irq_i) begin
      next_st.swi_pend = 1'b1;
    end
  end

  // state register feeding the strobe and vector outputs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{latch: PIC_LATCH_RST, master_irq_enable: 1'b0, swi_pend: 1'b0, req: 1'b0,
              vec: PIC_VEC_RESET, prio: 6'h00, stk: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign accept_req_o = st.req;
  assign vector_o = st.vec;
  assign prio_o = st.prio;
  assign stacked_imf_o = st.stk;
  assign master_irq_enable_o = st.master_irq_enable;
  assign request_latch_o = st.latch;

  // Checks on the offer and acceptance behaviour
  a_ack_clears_imf: assert property (@(posedge clk_i) disable iff (!rst_n)
    (accept_ack_i && st.req && !master_set_i) |=> !st.master_irq_enable && st.stk == $past(st.master_irq_enable))
    else $error("master enable not stacked and cleared on accept");
  a_ack_clears_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
    (accept_ack_i && st.req && !irq_src_i[st.prio]) |=> !st.latch[$past(st.prio)])
    else $error("accepted latch not cleared");
  a_src_sets_latch: assert property (@(posedge clk_i) disable iff (!rst_n)
    irq_src_i[12] |=> st.latch[12])
    else $error("request did not set latch");
  a_reserved_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
    !st.latch[4] && !st.latch[37] && !st.latch[1])
    else $error("reserved latch set");
  a_mask_blocks: assert property (@(posedge clk_i) disable iff (!rst_n)
    (st.req && st.prio > PIC_PRIO_WDT) |-> $past(st.master_irq_enable))
    else $error("maskable offered with master enable clear");
  a_vec_match: assert property (@(posedge clk_i) disable iff (!rst_n)
    st.req |-> st.vec == pic_vec_of(st.prio))
    else $error("vector does not match priority");
  a_vec_ends: assert property (@(posedge clk_i) disable iff (!rst_n)
    pic_vec_of(6'd31) == 20'hfff80 && pic_vec_of(6'd39) == 20'hfff20)
    else $error("vector table ends wrong");
  a_wdt_nmi: assert property (@(posedge clk_i) disable iff (!rst_n)
    (st.latch[2] && !st.swi_pend && !(accept_ack_i && st.req)) |=> st.req && st.prio == 6'h02)
    else $error("watchdog not offered regardless of enables");
  a_ext0_pin: assert property (@(posedge clk_i) disable iff (!rst_n)
    (st.req && st.prio == PIC_PRIO_EXT0) |-> $past(ext0_pin_function_enable_i))
    else $error("ext 0 offered without pin enable");
endmodule

// ==== tb/pic_cpu_model.sv ====
// Purpose: CPU core stand-in that accepts offered interrupts.
// Assumes: Offer is a level; acknowledge is a one-cycle pulse.
// Notes: dly_i sets how many cycles the core waits before taking.
`timescale 1ns/10ps
module pic_cpu_model (
  input wire logic clk_i, // System clock
  input wire logic nrst_i, // Reset, active low
  input wire logic accept_req_i, // Offer from controller
  input wire logic [1:0] dly_i, // Wait before acknowledge
  output logic accept_ack_o // Acknowledge pulse
);
  logic [1:0] cnt;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      accept_ack_o <= 1'b0;
      cnt <= 2'h0;
    end else if (accept_ack_o || !accept_req_i) begin
      accept_ack_o <= 1'b0; // Pulse only, never held past the taking edge
      cnt <= 2'h0;
    end else if (cnt == dly_i) begin
      accept_ack_o <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

// ==== tb/prioritized_interrupt_controller_test.sv ====
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: Inputs change on rising edges, outputs read on falling edges.
// Notes: Vectors are computed here from the priority index.
`timescale 1ns/10ps
module prioritized_interrupt_controller_test import pic_pkg::*;;
  logic clk_i = 1'b0, nrst_i = 1'b0, sw = 1'b0, mset = 1'b0, mclr = 1'b0;
  logic rmask = 1'b0, rnmi = 1'b0, rstk = 1'b0, pin = 1'b1, ack, req, master_irq_enable, stk;
  logic [39:0] src = 40'h0, en = 40'h0, clr = 40'h0, lat;
  logic [19:0] vec;
  logic [5:0] prio;
  logic [1:0] dly = 2'h0;
  int n_errors = 0, check_count = 0;
  pic_ctrl i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .irq_src_i(src), .software_irq_i(sw),
    .source_enable_flag_i(en), .master_set_i(mset), .master_clr_i(mclr), .ret_mask_i(rmask),
    .ret_nmi_i(rnmi), .ret_stacked_i(rstk), .latch_clr_i(clr),
    .ext0_pin_function_enable_i(pin), .accept_ack_i(ack), .accept_req_o(req), .vector_o(vec),
    .prio_o(prio), .stacked_imf_o(stk), .master_irq_enable_o(master_irq_enable), .request_latch_o(lat));
  pic_cpu_model i_cpu (.clk_i(clk_i), .nrst_i(nrst_i), .accept_req_i(req), .dly_i(dly),
    .accept_ack_o(ack));
  // Free-running 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task summarize;
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Bounded wait for the offer to reach a level
  task wreq(input logic v);
    int n;
    for (n = 0; n < 30 && req !== v; n++) @(negedge clk_i);
    if (n == 30) begin
      n_errors++;
      summarize();
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task pulse(input logic [39:0] s);
    step(1);
    src <= s;
    step(1);
    src <= 40'h0;
  endtask
  // Expect one offer, then the core takes it
  task svc(input int i, input logic [19:0] v, input logic pre);
    wreq(1'b1);
    chk("vector", vec, v);
    chk("prio", prio, i);
    wreq(1'b0);
    chk("latch", lat[i], 1'b0);
    chk("imf", master_irq_enable, 1'b0);
    chk("stacked", stk, pre);
    @(posedge clk_i);
  endtask
  task t_sweep;
    en <= '1;
    for (int i = 3; i < 40; i++) begin
      step(1);
      mset <= 1'b1;
      step(1);
      mset <= 1'b0;
      pulse(40'h1 << i);
      if (PIC_RESERVED_MAP[i]) begin
        step(2);
        @(negedge clk_i);
        chk("reserved", lat[i], 1'b0);
      end
      else svc(i, i < 32 ? 20'hffffc - 20'h4 * i : 20'hfff3c - 20'h4 * (i - 32), 1'b1);
    end
  endtask
  task t_prio;
    dly <= 2'h3;
    mset <= 1'b1;
    pulse(40'h120);
    mset <= 1'b0;
    svc(5, 20'hfffe8, 1'b1);
    rmask <= 1'b1; // return reopens nesting
    step(1);
    rmask <= 1'b0;
    svc(8, 20'hfffdc, 1'b1);
    dly <= 2'h0;
  endtask
  task t_mask;
    mset <= 1'b1;
    en <= 40'h0;
    pin <= 1'b0;
    pulse(40'h48);
    en <= 40'h8; // Ext 0 enabled but its pin function still off
    mset <= 1'b0;
    step(4);
    @(negedge clk_i);
    chk("masked", req, 1'b0);
    chk("held", lat[6] & lat[3], 1'b1);
    step(1);
    clr <= 40'h48;
    step(1);
    clr <= 40'h0;
    step(1);
    @(negedge clk_i);
    chk("cleared", lat & 40'h48, 40'h0);
    step(1);
  endtask
  task t_nmi;
    mclr <= 1'b1;
    step(1);
    mclr <= 1'b0;
    pulse(40'h4);
    svc(2, PIC_VEC_WDT, 1'b0); // master enable already cleared, so zero is stacked
    rnmi <= 1'b1;
    step(1);
    rnmi <= 1'b0;
    sw <= 1'b1;
    step(1);
    sw <= 1'b0;
    svc(1, PIC_VEC_SWI, 1'b0);
  endtask
  initial begin
    step(2);
    @(negedge clk_i);
    chk("rst vector", vec, PIC_VEC_RESET);
    chk("rst latch", lat, 40'h0);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    step(4);
    t_sweep();
    t_prio();
    t_mask();
    t_nmi();
    summarize();
  end
endmodule
